// *** verilog/iss_pkg.sv ***
// shared constants and types for the input state serializer
package iss_pkg;
  localparam int ISS_NUM_INPUTS = 8;
  localparam int ISS_LONG_LEN = 16;
  localparam int ISS_SHORT_LEN = 8;
  localparam logic [4:0] ISS_LONG_LEN_C = 5'h10;
  localparam logic [4:0] ISS_SHORT_LEN_C = 5'h08;
  // control bit positions of the long word
  localparam int ISS_POS_STOP_HI = 0;
  localparam int ISS_POS_STOP_LO = 1;
  localparam int ISS_POS_CHECK_LO = 2;
  localparam int ISS_POS_OVERTEMP = 6;
  localparam int ISS_POS_LOW_SUPPLY = 7;
  localparam int ISS_POS_DATA_LO = 8;
  // parity coverage masks over the eight inputs, one per check bit (1..4)
  localparam logic [7:0] ISS_CHECK_MASK_1 = 8'h5b;
  localparam logic [7:0] ISS_CHECK_MASK_2 = 8'h6d;
  localparam logic [7:0] ISS_CHECK_MASK_3 = 8'h8e;
  localparam logic [7:0] ISS_CHECK_MASK_4 = 8'hf0;
  localparam logic [15:0] ISS_WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    ISS_IDLE = 2'b00,
    ISS_SHIFT = 2'b01,
    ISS_DONE = 2'b11
  } iss_state_t;

  // monitor levels coming from the analogue side, all active low like the pins
  typedef struct packed {
    logic power_ok_n;
    logic low_supply_alarm_n;
    logic overtemp_alarm_n;
  } iss_status_t;

  // serial output pair with their output enables (low = driving)
  typedef struct packed {
    logic data;
    logic data_oe_n;
    logic data_inv;
    logic data_inv_oe_n;
  } iss_serial_out_t;
endpackage

// *** verilog/iss_hyst.sv ***
// hysteresis alarm latch driven by on (trip) and off (release) comparator levels
`timescale 1ns/1ps
module iss_hyst (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trip_i,
  input wire logic release_i,
  output logic alarm_n_o
);
  logic alarm_n_q;

  // alarm is active low; trip wins when both thresholds report together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_n_q <= 1'b1;
    end else if (trip_i) begin
      alarm_n_q <= 1'b0;
    end else if (release_i) begin
      alarm_n_q <= 1'b1;
    end
  end

  assign alarm_n_o = alarm_n_q;

  chk_trip_lowers: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_i |=> !alarm_n_q) else $error("alarm not asserted after trip");
  chk_hold_between: assert property (@(posedge clk_i) disable iff (rst_i)
    (!trip_i && !release_i) |=> $stable(alarm_n_q)) else $error("alarm moved inside band");
endmodule // iss_hyst

// *** verilog/iss_serializer.sv ***
// input state serializer: spi mode 0 slave sending input states and alarms
`timescale 1ns/1ps
module iss_serializer
  import iss_pkg::*;
#(
  parameter int NUM_INPUTS = ISS_NUM_INPUTS
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic MOSI_I,
  input wire logic [NUM_INPUTS-1:0] FIELD_IN_I,
  input wire logic FRAME_LENGTH_SELECT_I,
  input wire logic SUPPLY_BELOW_ON_I,
  input wire logic SUPPLY_ABOVE_OFF_I,
  input wire logic TEMP_ABOVE_ON_I,
  input wire logic TEMP_BELOW_OFF_I,
  input wire logic FIELD_SUPPLY_LOW_I,
  input wire logic LOGIC_SUPPLY_LOW_I,
  output logic MISO_O,
  output logic MISO_OE_N_O,
  output logic MISO_N_O,
  output logic MISO_N_OE_N_O,
  output logic [7:0] MOSI_CAPTURE_O,
  output logic LOW_SUPPLY_ALARM_N_O,
  output logic OVERTEMP_ALARM_N_O
);
  // check bit = xnor over the masked inputs
  function automatic logic check_xnor(input logic [7:0] data, input logic [7:0] mask);
    check_xnor = ~(^(data & mask));
  endfunction

  // ---------------- system clock domain ----------------
  logic [NUM_INPUTS-1:0] in_s1_q;
  logic [NUM_INPUTS-1:0] in_s2_q;
  logic [5:0] mon_s1_q;
  logic [5:0] mon_s2_q;
  logic len_s1_q;
  logic len_s2_q;
  logic low_supply_n;
  logic overtemp_n;
  logic power_ok_n_q;
  iss_status_t status;
  logic [15:0] word_d;
  logic [15:0] word_q;
  logic long_q;
  logic cs_s1_q;
  logic cs_s2_q;

  // select brought into the system domain; word_q only moves while deselected,
  // so the link domain reads a frozen word during a frame.
  // limitation: frames need select high for at least 3 system clocks between them
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= CS_N_I;
      cs_s2_q <= cs_s1_q;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      mon_s1_q <= '0;
      mon_s2_q <= '0;
      len_s1_q <= 1'b0;
      len_s2_q <= 1'b0;
    end else begin
      in_s1_q <= FIELD_IN_I;
      in_s2_q <= in_s1_q;
      mon_s1_q <= {SUPPLY_BELOW_ON_I, SUPPLY_ABOVE_OFF_I, TEMP_ABOVE_ON_I,
                   TEMP_BELOW_OFF_I, FIELD_SUPPLY_LOW_I, LOGIC_SUPPLY_LOW_I};
      mon_s2_q <= mon_s1_q;
      len_s1_q <= FRAME_LENGTH_SELECT_I;
      len_s2_q <= len_s1_q;
    end
  end

  iss_hyst u_supply_alarm (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .trip_i(mon_s2_q[5]),
    .release_i(mon_s2_q[4]),
    .alarm_n_o(low_supply_n)
  );

  iss_hyst u_temp_alarm (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .trip_i(mon_s2_q[3]),
    .release_i(mon_s2_q[2]),
    .alarm_n_o(overtemp_n)
  );

  // power reset is active low; raised when either supply sags
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      power_ok_n_q <= 1'b0;
    end else begin
      power_ok_n_q <= ~(mon_s2_q[1] | mon_s2_q[0]);
    end
  end

  assign status = '{power_ok_n: power_ok_n_q, low_supply_alarm_n: low_supply_n,
                    overtemp_alarm_n: overtemp_n};

  always_comb begin
    word_d = ISS_WORD_RST;
    word_d[ISS_POS_DATA_LO +: 8] = in_s2_q[7:0];
    word_d[ISS_POS_LOW_SUPPLY] = status.low_supply_alarm_n;
    word_d[ISS_POS_OVERTEMP] = status.overtemp_alarm_n;
    word_d[ISS_POS_CHECK_LO + 3] = check_xnor(in_s2_q[7:0], ISS_CHECK_MASK_1);
    word_d[ISS_POS_CHECK_LO + 2] = check_xnor(in_s2_q[7:0], ISS_CHECK_MASK_2);
    word_d[ISS_POS_CHECK_LO + 1] = check_xnor(in_s2_q[7:0], ISS_CHECK_MASK_3);
    word_d[ISS_POS_CHECK_LO] = check_xnor(in_s2_q[7:0], ISS_CHECK_MASK_4);
    word_d[ISS_POS_STOP_LO] = 1'b0;
    word_d[ISS_POS_STOP_HI] = 1'b1;
    // sleeping device sends all zeros, which also drops the stop bit
    if (!status.power_ok_n) begin
      word_d = ISS_WORD_RST;
    end
  end

  // word is presented as a registered level; the link domain loads it into the shifter at the first falling serial clock edge
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      word_q <= ISS_WORD_RST;
      long_q <= 1'b0;
    end else if (cs_s2_q) begin
      word_q <= word_d;
      long_q <= len_s2_q;
    end
  end

  assign LOW_SUPPLY_ALARM_N_O = low_supply_n;
  assign OVERTEMP_ALARM_N_O = overtemp_n;

  // ---------------- link (serial clock) domain ----------------
  // select high acts as frame reset so the sck domain needs no free-running edges.
  // the word is quasi-static relative to a frame (inputs are filtered, slow); a
  // bit changing exactly at select fall may be caught either way, same as a pin.
  logic [15:0] shift_q;
  logic [4:0] sent_q;
  logic [7:0] mosi_q;
  logic frame_long;
  iss_state_t state_q;

  assign frame_long = long_q;

  // shift on falling edge, clear asynchronously while deselected
  always_ff @(negedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      shift_q <= ISS_WORD_RST;
      sent_q <= 5'h00;
      state_q <= ISS_IDLE;
    end else begin
      case (state_q)
        ISS_IDLE: begin
          state_q <= ISS_SHIFT;
          sent_q <= 5'h01;
          shift_q <= {word_q[14:0], 1'b0};
        end
        ISS_SHIFT: begin
          shift_q <= {shift_q[14:0], 1'b0};
          sent_q <= sent_q + 5'h01;
          if (sent_q == (frame_long ? ISS_LONG_LEN_C : ISS_SHORT_LEN_C) - 5'h01) begin
            state_q <= ISS_DONE;
          end
        end
        ISS_DONE: begin
          state_q <= ISS_DONE;
        end
        default: begin
          state_q <= ISS_IDLE;
        end
      endcase
    end
  end

  // host data captured on rising edge; kept for observation only
  always_ff @(posedge SCK_I) begin
    mosi_q <= {mosi_q[6:0], MOSI_I};
  end
  assign MOSI_CAPTURE_O = mosi_q;

  // first bit is the msb of the live word, so data appears right at select fall
  logic tx_bit;
  always_comb begin
    case (state_q)
      ISS_IDLE: tx_bit = word_q[15];
      ISS_SHIFT: tx_bit = shift_q[15];
      ISS_DONE: tx_bit = 1'b0;
      default: tx_bit = 1'b0;
    endcase
    if (!power_ok_n_q) begin
      tx_bit = 1'b0;
    end
  end

  iss_serial_out_t so;
  assign so.data = tx_bit;
  assign so.data_inv = ~tx_bit;
  assign so.data_oe_n = CS_N_I;
  assign so.data_inv_oe_n = CS_N_I;

  assign MISO_O = so.data;
  assign MISO_N_O = so.data_inv;
  assign MISO_OE_N_O = so.data_oe_n;
  assign MISO_N_OE_N_O = so.data_inv_oe_n;

  chk_out_complement: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    MISO_N_O == ~MISO_O) else $error("inverted output not complement");
  chk_deselect_hiz: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    CS_N_I |-> (MISO_OE_N_O && MISO_N_OE_N_O)) else $error("driving while deselected");
  chk_powerloss_low: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (!power_ok_n_q && !CS_N_I) |-> (!MISO_O && MISO_N_O)) else $error("output not low");
  chk_power_reset: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (mon_s2_q[1] || mon_s2_q[0]) |=> !power_ok_n_q) else $error("power reset missed");
  chk_stop_bit: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    power_ok_n_q |-> (word_d[0] && !word_d[1])) else $error("stop bits wrong");
  chk_sleep_word: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !power_ok_n_q |-> word_d == ISS_WORD_RST) else $error("sleep word not zero");
  chk_data_place: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    power_ok_n_q |-> word_d[15:8] == in_s2_q[7:0]) else $error("data misplaced");
  chk_alarm_place: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    power_ok_n_q |-> (word_d[7] == low_supply_n && word_d[6] == overtemp_n))
    else $error("alarm bits misplaced");
  chk_frame_count: assert property (@(negedge SCK_I) disable iff (CS_N_I)
    (state_q == ISS_SHIFT) |-> sent_q < ISS_LONG_LEN_C) else $error("frame overrun");
endmodule // iss_serializer

// *** test/iss_host_model.sv ***
// serial host model: mode 0 master that clocks one frame on the link clock
`timescale 1ns/1ps
module iss_host_model (
  input wire logic miso_i,
  input wire logic miso_n_i,
  input wire logic oe_n_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // the receive register is 16 bits long so that a long word fits whole
  task automatic frame(input int len, input logic [15:0] tx, output logic [15:0] rx,
                       output logic [15:0] rxn, output logic oe_n);
    rx = 16'h0000;
    rxn = 16'h0000;
    oe_n = 1'b0;
    cs_n_o = 1'b0;
    for (int i = 0; i < len; i++) begin
      mosi_o = tx[15-i];
      #3;
      sck_o = 1'b1;
      rx = {rx[14:0], miso_i};
      rxn = {rxn[14:0], miso_n_i};
      oe_n = oe_n | oe_n_i;
      #3;
      sck_o = 1'b0;
    end
    #4;
    cs_n_o = 1'b1;
    // a released line must not keep showing the last bit
    mosi_o = ~mosi_o;
  endtask
endmodule // iss_host_model

// *** test/tb_top.sv ***
// self-checking bench for the input state serializer
`timescale 1ns/1ps
module tb_top;
  import iss_pkg::*;
  logic mclk, srst, fls, sbo, sao, tao, tbo, fsl, lsl, sck, cs_n, mosi;
  logic miso, miso_oe_n, miso_n, miso_n_oe_n, uva_n, ota_n;
  logic [7:0] field, cap;
  logic [15:0] rx, rxn;
  logic oe;
  int num_errors = 0;
  int cmp_count = 0;
  iss_serializer iss_serializer_i (.MCLK_I(mclk), .SRST_I(srst), .SCK_I(sck), .CS_N_I(cs_n),
    .MOSI_I(mosi), .FIELD_IN_I(field), .FRAME_LENGTH_SELECT_I(fls), .SUPPLY_BELOW_ON_I(sbo),
    .SUPPLY_ABOVE_OFF_I(sao), .TEMP_ABOVE_ON_I(tao), .TEMP_BELOW_OFF_I(tbo),
    .FIELD_SUPPLY_LOW_I(fsl), .LOGIC_SUPPLY_LOW_I(lsl), .MISO_O(miso), .MISO_OE_N_O(miso_oe_n),
    .MISO_N_O(miso_n), .MISO_N_OE_N_O(miso_n_oe_n), .MOSI_CAPTURE_O(cap),
    .LOW_SUPPLY_ALARM_N_O(uva_n), .OVERTEMP_ALARM_N_O(ota_n));
  iss_host_model iss_host_model_i (.miso_i(miso), .miso_n_i(miso_n), .oe_n_i(miso_oe_n),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [15:0] exp_word(logic [7:0] d, logic uv, logic ot);
    exp_word = {d, uv, ot, ~^(d & ISS_CHECK_MASK_1), ~^(d & ISS_CHECK_MASK_2),
                ~^(d & ISS_CHECK_MASK_3), ~^(d & ISS_CHECK_MASK_4), 2'b01};
  endfunction
  // inputs pass two synchronisers and up to two registers (alarm latch, word), so settle well past that
  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask
  task automatic t_long(input logic [7:0] d);
    @(posedge mclk);
    field <= d;
    fls <= 1'b1;
    settle();
    iss_host_model_i.frame(16, 16'ha5c3, rx, rxn, oe);
    #1;
    chk("long word", rx, exp_word(d, 1'b1, 1'b1));
    chk("inverted", rxn, ~rx);
    chk("enable in frame", {15'h0000, oe}, 16'h0000);
    chk("enable idle", {14'h0000, miso_oe_n, miso_n_oe_n}, 16'h0003);
    chk("mosi capture", {8'h00, cap}, 16'h00c3);
  endtask
  task automatic t_short;
    @(posedge mclk);
    field <= 8'h96;
    fls <= 1'b0;
    settle();
    iss_host_model_i.frame(8, 16'h3c00, rx, rxn, oe);
    chk("short word", rx, 16'h0096);
    chk("short capture", {8'h00, cap}, 16'h003c);
  endtask
  task automatic t_alarms;
    @(posedge mclk);
    fls <= 1'b1;
    sbo <= 1'b1;
    tao <= 1'b1;
    settle();
    iss_host_model_i.frame(16, 16'h0000, rx, rxn, oe);
    chk("alarm word", rx, exp_word(8'h96, 1'b0, 1'b0));
    @(posedge mclk);
    sbo <= 1'b0;
    tao <= 1'b0;
    settle();
    chk("alarm hold", {14'h0000, uva_n, ota_n}, 16'h0000);
    @(posedge mclk);
    sao <= 1'b1;
    tbo <= 1'b1;
    settle();
    chk("alarm release", {14'h0000, uva_n, ota_n}, 16'h0003);
    @(posedge mclk);
    sao <= 1'b0;
    tbo <= 1'b0;
  endtask
  task automatic t_power(input logic [1:0] low);
    @(posedge mclk);
    {fsl, lsl} <= low;
    settle();
    iss_host_model_i.frame(16, 16'hffff, rx, rxn, oe);
    #1;
    chk("power loss", rx, 16'h0000);
    chk("power loss inv", rxn, 16'hffff);
    chk("power idle", {14'h0000, miso_oe_n, miso_n_oe_n}, 16'h0003);
    @(posedge mclk);
    {fsl, lsl} <= 2'b00;
  endtask
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    {srst, fls, sbo, sao, tao, tbo, fsl, lsl} = 8'h80;
    field = 8'h00;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_long(8'h00);
    t_long(8'hff);
    t_long(8'h81);
    t_long(8'h5a);
    t_long(8'h37);
    t_short();
    t_alarms();
    t_power(2'b10);
    t_power(2'b01);
    t_long(8'he4);
    stop_test();
  end
endmodule // tb_top
